//--- verilog/rdta_pkg.sv
package rdta_pkg;

  // Register indices on the serial bus
  localparam logic [7:0] REG_HIGH_LIMIT = 8'h00;
  localparam logic [7:0] REG_LOW_LIMIT  = 8'h03;
  localparam logic [7:0] REG_COUNT_CFG  = 8'h06;
  localparam logic [7:0] REG_CRIT_LIMIT = 8'h07;
  localparam logic [7:0] REG_MASK_HYST  = 8'h0c;
  localparam logic [7:0] REG_ALARM      = 8'h0d;
  localparam logic [7:0] REG_STATUS     = 8'h0e;
  localparam logic [7:0] REG_CONFIG     = 8'h0f;
  localparam logic [7:0] REG_TEMP_MSB   = 8'h10;
  localparam logic [7:0] REG_TEMP_LSB   = 8'h11;

  // Field positions
  localparam int MASK_CH1_BIT  = 7;
  localparam int ALARM_HI_BIT  = 3;
  localparam int ALARM_LO_BIT  = 2;
  localparam int FAULT_CH1_BIT = 1;
  localparam int HYST_W        = 5;
  localparam int TEMP_W        = 11;
  localparam int FRAC_W        = 3;

  // Reset values
  localparam logic [7:0]        HIGH_LIMIT_RST = 8'h7f;
  localparam logic [7:0]        LOW_LIMIT_RST  = 8'h7f;
  localparam logic [6:0]        CRIT_LIMIT_RST = 7'h7f;
  localparam logic [HYST_W-1:0] HYST_RST       = 5'h04;
  localparam logic [3:0]        CONV_RATE_RST  = 4'h2;
  localparam logic [3:0]        CONV_RATE_MAX  = 4'ha;

  // Conversion timing: 1/16 s is the fastest period
  localparam longint CLK_PERIOD_NS     = 8;
  localparam longint CONV_BASE_NS      = 62_500_000;
  localparam longint CONV_BASE_CYC_DEF = CONV_BASE_NS / CLK_PERIOD_NS;
  localparam int     CONV_CNT_W        = 34;

  // Bus address of the device (value is arbitrary)
  localparam logic [6:0] DEV_ADDR_DEF = 7'h4c;

  typedef struct packed {
    logic       fault_clear;
    logic       one_shot;
    logic       dyn_avg_en;
    logic [3:0] conv_rate;
    logic       rsvd;
  } rdta_cfg_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic [1:0] consec;
    logic [1:0] avg_sel;
  } rdta_count_cfg_t;

  typedef struct packed {
    logic       rsvd7;
    logic       high_flag;
    logic       low_flag;
    logic       fault_flag;
    logic       rsvd3;
    logic       crit_flag;
    logic [1:0] rsvd1_0;
  } rdta_status_t;

  // Shift that divides the sum of 1, 4, 8 or 16 samples
  function automatic logic [2:0] rdta_avg_shift(input logic [1:0] sel);
    logic [2:0] sh;
    sh = (sel == 2'h0) ? 3'h0 : 3'(sel) + 3'h1;
    return sh;
  endfunction : rdta_avg_shift

endpackage : rdta_pkg

//--- verilog/rdta_avg.sv
module rdta_avg
  import rdta_pkg::*;
#(
  parameter int W     = 11,
  parameter int ACC_W = 15
)
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // Sample stream
  input  wire logic                in_valid,
  input  wire logic                in_last,
  input  wire logic signed [W-1:0] in_code,
  input  wire logic [2:0]          shift,
  // Averaged result
  output logic                     out_valid,
  output logic signed [W-1:0]      out_code
);

  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] quot;

  assign sum  = acc + ACC_W'(in_code);
  assign quot = sum >>> shift;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      acc       <= '0;
      out_valid <= 1'h0;
      out_code  <= '0;
    end
    else
    begin
      out_valid <= in_valid & in_last;
      if (in_valid & in_last)
      begin
        acc      <= '0;
        out_code <= quot[W-1:0];
      end
      else if (in_valid)
      begin
        acc <= sum;
      end
    end
  end

endmodule : rdta_avg

//--- verilog/rdta_top.sv
// Operation
// - Each result is an 11-bit code, one step equal to 0.125 degree.
// - Diode fault check runs at the start of every measurement.
// - Fault means anode-cathode open, or either diode pin shorted to supply.
// - A fault drives alert low and forces both result bytes to zero.
// - While a fault persists, alarm register bit 1 reads one.
// - A fault also sets the open/short flag, status bit 4.
// - High limit at register 0, signed whole degrees, default 127.
// - Low limit at register 3, same format, default 127.
// - An activated threshold alert sets status bit 6 high or bit 5 low.
// - Writing one to config bit 7 clears threshold and critical flags.
// - Mask bit 7 keeps threshold alerts off the alert pin only.
// - Alert needs 1 to 4 consecutive events, register 6 bits 3:2.
// - Alarm register bits 3:2 show that a threshold alert occurred.
// - Continuous conversions at the set rate, or one per request in standby.
// - Dynamic averaging takes 1, 4, 8 or 16 conversions.
// - Reaching the critical limit sets status bit 2 and drives therm low.
module rdta_top
  import rdta_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR      = DEV_ADDR_DEF,
  parameter longint      CONV_BASE_CYC = CONV_BASE_CYC_DEF,
  parameter int          ACC_W         = 15
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Serial register bus, open-drain data
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  // Converter handshake
  output logic                   adc_start,
  input  wire logic              adc_done,
  input  wire logic [TEMP_W-1:0] adc_code,
  // Diode fault detectors, asynchronous
  input  wire logic              diode_open_in,
  input  wire logic              diode_anode_in_short,
  input  wire logic              diode_cathode_in_short,
  // Alarm pins
  output logic                   alert_n,
  output logic                   therm_n
);

  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_RACK} rdta_bus_t;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} rdta_phase_t;
  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_WAIT, S_AVG} rdta_conv_t;

  // Input synchronisers
  logic [1:0] scl_q, sda_q;
  logic       scl_d, sda_d;
  logic [2:0] flt_m, flt_s;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      scl_d <= 1'h1;
      sda_d <= 1'h1;
      flt_m <= 3'h0;
      flt_s <= 3'h0;
    end
    else
    begin
      scl_q <= {scl_q[0], scl_in};
      sda_q <= {sda_q[0], sda_in};
      scl_d <= scl_q[1];
      sda_d <= sda_q[1];
      flt_m <= {diode_open_in, diode_anode_in_short, diode_cathode_in_short};
      flt_s <= flt_m;
    end
  end

  wire scl_rise = scl_q[1] & ~scl_d;
  wire scl_fall = ~scl_q[1] & scl_d;
  wire bus_start = scl_q[1] & scl_d & sda_d & ~sda_q[1];
  wire bus_stop  = scl_q[1] & scl_d & ~sda_d & sda_q[1];
  wire fault_any = |flt_s;

  // Bus slave state
  rdta_bus_t   bus_st;
  rdta_phase_t phase;
  logic [7:0]  shreg, ptr, wr_idx, wr_data, rd_data;
  logic [3:0]  bit_cnt;
  logic        rd_mode, nack, wr_en;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_st   <= I_IDLE;
      phase    <= PH_ADDR;
      shreg    <= 8'h00;
      ptr      <= 8'h00;
      wr_idx   <= 8'h00;
      wr_data  <= 8'h00;
      bit_cnt  <= 4'h0;
      rd_mode  <= 1'h0;
      nack     <= 1'h0;
      wr_en    <= 1'h0;
      sda_oe_n <= 1'h1;
      sda_out  <= 1'h0;
    end
    else
    begin
      wr_en   <= 1'h0;
      sda_out <= 1'h0;
      if (bus_start)
      begin
        bus_st   <= I_RX;
        phase    <= PH_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'h1;
      end
      else if (bus_stop)
      begin
        bus_st   <= I_IDLE;
        sda_oe_n <= 1'h1;
      end
      else
      begin
        unique case (bus_st)
          I_IDLE: ;
          I_RX:
            if (scl_rise)
            begin
              shreg   <= {shreg[6:0], sda_q[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              if (phase != PH_ADDR || shreg[7:1] == DEV_ADDR)
              begin
                sda_oe_n <= 1'h0;
                bus_st   <= I_ACK;
              end
              else
                bus_st <= I_IDLE;
              if (phase == PH_ADDR)
                rd_mode <= shreg[0];
              else if (phase == PH_PTR)
                ptr <= shreg;
              else
              begin
                wr_en   <= 1'h1;
                wr_idx  <= ptr;
                wr_data <= shreg;
                ptr     <= ptr + 8'h01;
              end
            end
          I_ACK:
            if (scl_fall)
            begin
              if (rd_mode && phase == PH_ADDR)
              begin
                shreg    <= rd_data;
                sda_oe_n <= rd_data[7];
                ptr      <= ptr + 8'h01;
                bus_st   <= I_TX;
              end
              else
              begin
                sda_oe_n <= 1'h1;
                bus_st   <= I_RX;
                phase    <= (phase == PH_ADDR) ? PH_PTR : PH_DATA;
              end
            end
          I_TX:
            if (scl_fall)
            begin
              if (bit_cnt == 4'h7)
              begin
                sda_oe_n <= 1'h1;
                bit_cnt  <= 4'h0;
                bus_st   <= I_RACK;
              end
              else
              begin
                shreg    <= {shreg[6:0], 1'h0};
                sda_oe_n <= shreg[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          I_RACK:
            if (scl_rise)
              nack <= sda_q[1];
            else if (scl_fall)
            begin
              if (nack)
                bus_st <= I_IDLE;
              else
              begin
                shreg    <= rd_data;
                sda_oe_n <= rd_data[7];
                ptr      <= ptr + 8'h01;
                bus_st   <= I_TX;
              end
            end
        endcase
      end
    end
  end

  // Software registers
  logic [7:0]        high_limit_ch1, low_limit_ch1;
  logic [6:0]        crit_limit;
  logic              mask_ch1;
  logic [HYST_W-1:0] crit_hyst;
  rdta_count_cfg_t   count_cfg;
  rdta_cfg_t         cfg;
  logic              wr_cfg, wr_count, fault_clr, shot_req;

  assign wr_cfg    = wr_en && wr_idx == REG_CONFIG;
  assign wr_count  = wr_en && wr_idx == REG_COUNT_CFG;
  assign fault_clr = wr_cfg && wr_data[7];
  assign shot_req  = wr_cfg && wr_data[6];

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      high_limit_ch1 <= HIGH_LIMIT_RST;
      low_limit_ch1  <= LOW_LIMIT_RST;
      crit_limit     <= CRIT_LIMIT_RST;
      mask_ch1       <= 1'h0;
      crit_hyst      <= HYST_RST;
      count_cfg      <= '0;
      cfg            <= '{conv_rate: CONV_RATE_RST, default: 1'h0};
    end
    else if (wr_en)
    begin
      if (wr_idx == REG_HIGH_LIMIT)
        high_limit_ch1 <= wr_data;
      if (wr_idx == REG_LOW_LIMIT)
        low_limit_ch1 <= wr_data;
      if (wr_idx == REG_CRIT_LIMIT)
        crit_limit <= wr_data[6:0];
      if (wr_idx == REG_MASK_HYST)
      begin
        mask_ch1  <= wr_data[MASK_CH1_BIT];
        crit_hyst <= wr_data[HYST_W-1:0];
      end
      if (wr_count)
        count_cfg <= '{rsvd: 4'h0, consec: wr_data[3:2],
                       avg_sel: wr_data[1:0]};
      if (wr_cfg)
        cfg <= '{fault_clear: 1'h0, one_shot: wr_data[6],
                 dyn_avg_en: wr_data[5], conv_rate: wr_data[4:1],
                 rsvd: wr_data[0]};
    end
  end

  // Conversion pacing
  logic [CONV_CNT_W-1:0] conv_cnt;
  logic [CONV_CNT_W-1:0] conv_period;
  logic [3:0]            rate_eff;
  logic                  conv_due;
  rdta_conv_t            conv_st;

  assign rate_eff    = (cfg.conv_rate > CONV_RATE_MAX) ? CONV_RATE_MAX
                                                       : cfg.conv_rate;
  assign conv_period = CONV_CNT_W'(CONV_BASE_CYC) << rate_eff;
  wire   rate_tick   = !cfg.one_shot && conv_cnt == '0;
  wire   next_due    = rate_tick | shot_req
                     | (conv_due & (conv_st == S_IDLE ? 1'h0 : 1'h1));

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_cnt <= '0;
      conv_due <= 1'h0;
    end
    else
    begin
      conv_due <= next_due;
      if (cfg.one_shot || conv_cnt >= conv_period - CONV_CNT_W'(1))
        conv_cnt <= '0;
      else
        conv_cnt <= conv_cnt + CONV_CNT_W'(1);
    end
  end

  // Measurement sequence
  logic [4:0]               smp_cnt;
  logic [2:0]               avg_sh;
  logic                     avg_valid;
  logic signed [TEMP_W-1:0] avg_code, temp;
  logic                     smp_last;

  assign avg_sh   = cfg.dyn_avg_en ? rdta_avg_shift(count_cfg.avg_sel)
                                   : 3'h0;
  assign smp_last = smp_cnt == ((5'h01 << avg_sh) - 5'h01);

  rdta_avg #(.W(TEMP_W), .ACC_W(ACC_W)) u_avg (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (conv_st == S_WAIT && adc_done),
    .in_last   (smp_last),
    .in_code   (adc_code),
    .shift     (avg_sh),
    .out_valid (avg_valid),
    .out_code  (avg_code)
  );

  // Limit comparison on the fresh average
  wire signed [TEMP_W-1:0] hi_ext   = {high_limit_ch1, FRAC_W'(0)};
  wire signed [TEMP_W-1:0] lo_ext   = {low_limit_ch1, FRAC_W'(0)};
  wire signed [TEMP_W-1:0] crit_ext = {1'h0, crit_limit, FRAC_W'(0)};
  wire high_evt  = avg_valid && avg_code > hi_ext;
  wire low_evt   = avg_valid && avg_code < lo_ext;
  wire crit_evt  = avg_valid && avg_code >= crit_ext;
  logic [2:0] cons_cnt;
  wire fire      = (high_evt | low_evt)
                 && cons_cnt >= {1'h0, count_cfg.consec};
  wire flt_event = conv_st == S_CHECK && fault_any;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_st   <= S_IDLE;
      adc_start <= 1'h0;
      smp_cnt   <= 5'h00;
      temp      <= '0;
      cons_cnt  <= 3'h0;
    end
    else
    begin
      adc_start <= 1'h0;
      unique case (conv_st)
        S_IDLE:
          if (conv_due)
            conv_st <= S_CHECK;
        S_CHECK:
          if (fault_any)
          begin
            temp    <= '0;
            conv_st <= S_IDLE;
          end
          else
          begin
            adc_start <= 1'h1;
            smp_cnt   <= 5'h00;
            conv_st   <= S_WAIT;
          end
        S_WAIT:
          if (adc_done)
          begin
            smp_cnt <= smp_cnt + 5'h01;
            if (smp_last)
              conv_st <= S_AVG;
            else
              adc_start <= 1'h1;
          end
        S_AVG:
          if (avg_valid)
          begin
            temp    <= avg_code;
            conv_st <= S_IDLE;
            if (!(high_evt | low_evt))
              cons_cnt <= 3'h0;
            else if (!fire)
              cons_cnt <= cons_cnt + 3'h1;
          end
      endcase
    end
  end

  // Flags: a set in the clearing cycle wins
  rdta_status_t status;
  logic         fault_now, alarm_hi, alarm_lo;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      status    <= '0;
      fault_now <= 1'h0;
      alarm_hi  <= 1'h0;
      alarm_lo  <= 1'h0;
      alert_n   <= 1'h1;
      therm_n   <= 1'h1;
    end
    else
    begin
      if (conv_st == S_CHECK)
        fault_now <= fault_any;
      status.fault_flag <= flt_event
                         | (status.fault_flag & ~fault_clr);
      status.high_flag  <= (fire & high_evt)
                         | (status.high_flag & ~fault_clr);
      status.low_flag   <= (fire & low_evt)
                         | (status.low_flag & ~fault_clr);
      status.crit_flag  <= crit_evt
                         | (status.crit_flag & ~fault_clr);
      alarm_hi <= (fire & high_evt) | (alarm_hi & ~fault_clr);
      alarm_lo <= (fire & low_evt) | (alarm_lo & ~fault_clr);
      alert_n  <= ~(flt_event | (fire & ~mask_ch1)
                  | (~alert_n & ~fault_clr));
      therm_n  <= ~(crit_evt | (~therm_n & ~fault_clr));
    end
  end

  // Read selection
  wire [7:0] alarm_byte = {4'h0, alarm_hi, alarm_lo, fault_now, 1'h0};
  assign rd_data =
      (ptr == REG_HIGH_LIMIT) ? high_limit_ch1 :
      (ptr == REG_LOW_LIMIT)  ? low_limit_ch1 :
      (ptr == REG_COUNT_CFG)  ? count_cfg :
      (ptr == REG_CRIT_LIMIT) ? {1'h0, crit_limit} :
      (ptr == REG_MASK_HYST)  ? {mask_ch1, 2'h0, crit_hyst} :
      (ptr == REG_ALARM)      ? alarm_byte :
      (ptr == REG_STATUS)     ? status :
      (ptr == REG_CONFIG)     ? cfg :
      (ptr == REG_TEMP_MSB)   ? temp[TEMP_W-1:FRAC_W] :
      (ptr == REG_TEMP_LSB)   ? {5'h00, temp[FRAC_W-1:0]} :
      8'h00;

endmodule : rdta_top

//--- sim/rdta_checker.sv
module rdta_checker
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_oe_n,
  // Converter
  input wire logic adc_start,
  input wire logic adc_done,
  // Diode faults
  input wire logic diode_open_in,
  input wire logic diode_anode_in_short,
  input wire logic diode_cathode_in_short,
  // Alarm pins
  input wire logic alert_n,
  input wire logic therm_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic       any_flt;
  logic [3:0] flt_age;
  logic [9:0] flt_run;
  assign any_flt = diode_open_in | diode_anode_in_short
                 | diode_cathode_in_short;
  // Cycles since a fault input was last high, saturating
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      flt_age <= 4'hf;
    else if (any_flt)
      flt_age <= 4'h0;
    else if (flt_age != 4'hf)
      flt_age <= flt_age + 4'h1;
  // Length of the present unbroken fault, saturating
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      flt_run <= 10'h000;
    else if (!any_flt)
      flt_run <= 10'h000;
    else if (flt_run != 10'h3ff)
      flt_run <= flt_run + 10'h001;
  sequence bus_quiet;
    $stable(scl_in) [*8];
  endsequence
  sequence fault_held;
    any_flt [*6];
  endsequence
  a_fault_no_start:
    assert property (fault_held ##0 !$past(adc_done) |-> !adc_start)
    else $error("conversion started with a diode fault");
  a_start_single:
    assert property (adc_start |=> !adc_start)
    else $error("adc_start wider than one cycle");
  a_fault_alert:
    assert property (flt_run == 10'h3ff |-> !alert_n)
    else $error("alert_n high during a lasting fault");
  a_alert_cause:
    assert property ($fell(alert_n) |-> $past(adc_done, 2) || flt_age < 4'h8)
    else $error("alert_n fell without a result or fault");
  a_alert_hold:
    assert property (bus_quiet ##0 !alert_n |=> !alert_n)
    else $error("alert_n released without a clear write");
  a_therm_cause:
    assert property ($fell(therm_n) |-> $past(adc_done, 2))
    else $error("therm_n fell without a new result");
  a_therm_hold:
    assert property (bus_quiet ##0 !therm_n |=> !therm_n)
    else $error("therm_n released without a clear write");
  a_oe_on_low:
    assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda_oe_n changed while scl high");
endmodule : rdta_checker

bind rdta_top rdta_checker u_chk (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .adc_start(adc_start), .adc_done(adc_done),
  .diode_open_in(diode_open_in),
  .diode_anode_in_short(diode_anode_in_short),
  .diode_cathode_in_short(diode_cathode_in_short),
  .alert_n(alert_n), .therm_n(therm_n)
);

//--- sim/rdta_conv_model.sv
module rdta_conv_model
  import rdta_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Converter handshake
  input  wire logic              adc_start,
  output logic                   adc_done,
  output logic [TEMP_W-1:0]      adc_code,
  // Scene from the bench
  input  wire logic [TEMP_W-1:0] temp_code,
  input  wire logic [3:0]        lat
);
  timeunit 1ns;
  timeprecision 100ps;
  logic              busy;
  logic [3:0]        cnt;
  logic [TEMP_W-1:0] held;
  // Code is only good with done; otherwise it shows the inverse
  assign adc_code = adc_done ? held : ~held;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      busy     <= 1'b0;
      cnt      <= 4'h0;
      adc_done <= 1'b0;
      held     <= '0;
    end
    else if (adc_start)
    begin
      busy     <= 1'b1;
      cnt      <= lat;
      adc_done <= 1'b0;
    end
    else if (busy && cnt == 4'h0)
    begin
      busy     <= 1'b0;
      adc_done <= 1'b1;
      held     <= temp_code;
    end
    else
    begin
      cnt      <= cnt - 4'h1;
      adc_done <= 1'b0;
    end
endmodule : rdta_conv_model

//--- sim/rdta_top_tb.sv
module rdta_top_tb
  import rdta_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = DEV_ADDR_DEF;
  logic              ref_clk = 1'b0;
  logic              rst     = 1'b1;
  logic              scl     = 1'b1;
  logic              sda_h   = 1'b1;
  logic [2:0]        flt     = 3'h0;
  logic [3:0]        lat     = 4'h1;
  logic [TEMP_W-1:0] tcode   = 11'h1a5;
  logic              sda_in, sda_out, sda_oe_n;
  logic              adc_start, adc_done, alert_n, therm_n;
  logic [TEMP_W-1:0] adc_code;
  int                n_fail   = 0;
  int                compares = 0;
  int                cyc      = 0;
  int                n_start  = 0;
  int                s0;
  // Open-drain data line with pull-up
  assign sda_in = sda_h & (sda_oe_n | sda_out);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    n_start <= n_start + int'(adc_start === 1'b1);
    if (cyc == 90000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  rdta_top #(.CONV_BASE_CYC(200)) dut (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .adc_start(adc_start),
    .adc_done(adc_done), .adc_code(adc_code),
    .diode_open_in(flt[0]), .diode_anode_in_short(flt[1]),
    .diode_cathode_in_short(flt[2]), .alert_n(alert_n),
    .therm_n(therm_n)
  );
  rdta_conv_model conv (
    .ref_clk(ref_clk), .rst(rst), .adc_start(adc_start),
    .adc_done(adc_done), .adc_code(adc_code), .temp_code(tcode),
    .lat(lat)
  );
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic pin(input string nm, input logic v, input logic e);
    check(nm, {7'h0, v}, {7'h0, e});
  endtask : pin
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  // A third of a bit time: five clocks, above the four the bus needs
  task automatic hw();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : hw
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      sda_h = d[i];
      hw();
      scl = 1'b1;
      hw();
      r[i] = sda_in;
      scl = 1'b0;
      hw();
    end
  endtask : xfer
  task automatic bus_start();
    sda_h = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    sda_h = 1'b0;
    hw();
    scl = 1'b0;
    hw();
  endtask : bus_start
  task automatic bus_stop();
    sda_h = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    sda_h = 1'b1;
    hw();
  endtask : bus_stop
  task automatic put(input logic [7:0] b);
    logic [8:0] r;
    xfer({b, 1'b1}, r);
    pin("ack", r[0], 1'b0);
  endtask : put
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_start();
    put({ADDR, 1'b0});
    put(a);
    put(d);
    bus_stop();
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input string nm);
    logic [8:0] r;
    bus_start();
    put({ADDR, 1'b0});
    put(a);
    bus_start();
    put({ADDR, 1'b1});
    xfer(9'h1ff, r);
    bus_stop();
    check(nm, r[8:1], e);
  endtask : rd_chk
  // Next result, then two more edges for flags and pins to land
  task automatic wait_done();
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    while (adc_done !== 1'b1 && k < 2000);
    pin("adc_done", adc_done, 1'b1);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : wait_done
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    rd_chk(REG_HIGH_LIMIT, 8'h7f, "high limit");
    rd_chk(REG_LOW_LIMIT, 8'h7f, "low limit");
    rd_chk(8'h20, 8'h00, "unmapped");
    pin("alert_n", alert_n, 1'b0);
    rd_chk(REG_STATUS, 8'h20, "status low");
    rd_chk(REG_ALARM, 8'h04, "alarm low");
    rd_chk(REG_TEMP_MSB, tcode[10:3], "temp msb");
    rd_chk(REG_TEMP_LSB, {5'h0, tcode[2:0]}, "temp lsb");
    wr(REG_LOW_LIMIT, 8'h00);
    rd_chk(REG_LOW_LIMIT, 8'h00, "low limit");
    wait_done();
    wr(REG_CONFIG, 8'h84);
    wait_done();
    pin("alert_n", alert_n, 1'b1);
    rd_chk(REG_STATUS, 8'h00, "status clr");
    // Each event count, one to four
    for (int n = 0; n < 4; n++)
    begin
      wr(REG_HIGH_LIMIT, 8'h7f);
      wait_done();
      wr(REG_CONFIG, 8'h84);
      wr(REG_COUNT_CFG, 8'(n << 2));
      wait_done();
      wr(REG_HIGH_LIMIT, 8'h34);
      for (int k = 0; k <= n; k++)
      begin
        wait_done();
        pin("alert_n", alert_n, k < n);
      end
    end
    rd_chk(REG_STATUS, 8'h40, "status high");
    rd_chk(REG_ALARM, 8'h08, "alarm high");
    wr(REG_HIGH_LIMIT, 8'h7f);
    wait_done();
    wr(REG_CONFIG, 8'h84);
    wr(REG_COUNT_CFG, 8'h00);
    wr(REG_MASK_HYST, 8'h84);
    wr(REG_CRIT_LIMIT, 8'h34);
    wr(REG_HIGH_LIMIT, 8'h34);
    wait_done();
    pin("alert_n", alert_n, 1'b1);
    pin("therm_n", therm_n, 1'b0);
    rd_chk(REG_STATUS, 8'h44, "status mask");
    tcode = 11'h0c8;
    wait_done();
    wr(REG_CONFIG, 8'h84);
    wait_done();
    pin("therm_n", therm_n, 1'b1);
    rd_chk(REG_STATUS, 8'h00, "status clr");
    // Each fault input in turn, slow converter
    lat = 4'h9;
    for (int i = 0; i < 3; i++)
    begin
      flt = 3'(1 << i);
      repeat (1100) @(posedge ref_clk);
      #1;
      pin("alert_n", alert_n, 1'b0);
      rd_chk(REG_TEMP_MSB, 8'h00, "fault msb");
      rd_chk(REG_TEMP_LSB, 8'h00, "fault lsb");
      rd_chk(REG_ALARM, 8'h02, "fault alarm");
      rd_chk(REG_STATUS, 8'h10, "fault status");
      flt = 3'h0;
      wait_done();
      wr(REG_CONFIG, 8'h84);
      pin("alert_n", alert_n, 1'b1);
    end
    // Standby: one conversion per request
    wr(REG_CONFIG, 8'h44);
    repeat (1000) @(posedge ref_clk);
    #1;
    s0 = n_start;
    repeat (1700) @(posedge ref_clk);
    #1;
    check("starts", 8'(n_start - s0), 8'h00);
    wr(REG_CONFIG, 8'h44);
    repeat (100) @(posedge ref_clk);
    #1;
    check("starts", 8'(n_start - s0), 8'h01);
    // Standby request with averaging of four samples
    tcode = 11'h1a5;
    wr(REG_COUNT_CFG, 8'h01);
    s0 = n_start;
    wr(REG_CONFIG, 8'h64);
    repeat (200) @(posedge ref_clk);
    #1;
    check("starts", 8'(n_start - s0), 8'h04);
    rd_chk(REG_TEMP_MSB, tcode[10:3], "avg msb");
    rd_chk(REG_TEMP_LSB, {5'h0, tcode[2:0]}, "avg lsb");
    print_verdict();
  end
endmodule : rdta_top_tb
